/* hw/vipc_pkg.sv */
package vipc_pkg;
   // ==========================================================
   // Sizes
   localparam int NODES      = 128;
   localparam int NODE_W     = 7;
   localparam int LVL_W      = 4;
   localparam int GRP_W      = (NODES > 64) ? 3 : 2;
   localparam int EXT_N      = 8;
   localparam int CH_N       = 8;
   localparam int CH_W       = 3;
   localparam int HWT_N      = 8;
   localparam int SLOT_W     = 8;

   // ==========================================================
   // Register map (byte addresses on a 12-bit bus address)
   localparam logic [11:0] CTRL_BASE  = 12'h000;
   localparam logic [11:0] MODE_BASE  = 12'h200;
   localparam logic [11:0] CPU_OFS    = 12'h400;
   localparam logic [11:0] VBASE_OFS  = 12'h404;
   localparam logic [11:0] STAT_OFS   = 12'h408;
   localparam logic [11:0] ROUTE_BASE = 12'h440;
   localparam logic [11:0] CH_BASE    = 12'h480;
   localparam logic [11:0] CH_SRC     = 12'h000;
   localparam logic [11:0] CH_DST     = 12'h004;
   localparam logic [11:0] CH_CTL     = 12'h008;

   // Node control word fields
   localparam int F_GRP   = 0;
   localparam int F_LVL   = 2;
   localparam int F_EN    = 6;
   localparam int F_FLAG  = 7;
   localparam int F_GEXT  = 8;
   // Mode word fields
   localparam int F_KIND  = 0;
   localparam int F_CH    = 2;
   // Processor status fields
   localparam int F_PLVL  = 0;
   localparam int F_GIE   = 4;
   localparam int F_SEG   = 5;

   localparam logic [31:0] VBASE_RST = 32'h0000_0000;

   // ==========================================================
   // Jump table slots
   localparam logic [SLOT_W-1:0] SLOT_NMI  = 8'h01;
   localparam logic [SLOT_W-1:0] SLOT_HWT0 = 8'h02;
   localparam logic [SLOT_W-1:0] SLOT_INT0 = 8'h10;

   typedef enum logic [1:0] {
      VIPC_ACT_INT,
      VIPC_ACT_XFER,
      VIPC_ACT_JTC,
      VIPC_ACT_RSV
   } vipc_act_t;

   typedef enum logic [1:0] {
      VIPC_PUSH_STAT,
      VIPC_PUSH_SEG,
      VIPC_PUSH_RET
   } vipc_push_t;
endpackage

/* hw/vipc_entry_seq.sv */
`timescale 1ns/1ps
module vipc_entry_seq
   import vipc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              start_i,
   input  wire logic              push_i,
   input  wire logic              seg_i,
   input  wire logic [31:0]       vec_i,
   input  wire logic              stk_ack_i,
   output logic                   stk_req_o,
   output vipc_pkg::vipc_push_t   stk_sel_o,
   output logic                   br_o,
   output logic [31:0]            br_addr_o,
   output logic                   busy_o
);
   // ==========================================================
   // Push sequence, then branch
   typedef enum {ES_IDLE, ES_PUSH, ES_BRANCH} vipc_es_t;
   vipc_es_t    st_q;
   vipc_push_t  sel_q;
   logic        seg_q;
   logic [31:0] vec_q;

   assign stk_req_o = (st_q == ES_PUSH);
   assign stk_sel_o = sel_q;
   assign busy_o    = (st_q != ES_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q  <= ES_IDLE;
         sel_q <= VIPC_PUSH_STAT;
         seg_q <= 1'b0;
         vec_q <= 32'h0000_0000;
      end else begin
         unique case (st_q)
            ES_IDLE: if (start_i) begin
               vec_q <= vec_i;
               seg_q <= seg_i;
               sel_q <= VIPC_PUSH_STAT;
               st_q  <= push_i ? ES_PUSH : ES_BRANCH; // R11 R18
            end
            ES_PUSH: if (stk_ack_i) begin
               // Order: status word, segment (segmented only), return address
               unique case (sel_q)
                  VIPC_PUSH_STAT: sel_q <= seg_q ? VIPC_PUSH_SEG : VIPC_PUSH_RET; // R11
                  VIPC_PUSH_SEG:  sel_q <= VIPC_PUSH_RET;
                  default:        st_q  <= ES_BRANCH;
               endcase
            end
            ES_BRANCH: st_q <= ES_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         br_o      <= 1'b0;
         br_addr_o <= 32'h0000_0000;
      end else begin
         br_o <= (st_q == ES_BRANCH);
         if (st_q == ES_BRANCH) begin
            br_addr_o <= vec_q; // R6
         end
      end
   end
endmodule

/* hw/vipc_top.sv */
// Functional notes
// R1 - Up to 128 request nodes, each given one of sixteen levels.
// R2 - Four group sub-levels up to 64 nodes, eight beyond that.
// R3 - Each node has a control word: pending flag, enable, priority.
// R4 - A node's request is raised by one specific source event.
// R5 - Several sources may share and set the same node.
// R6 - A taken request branches to a fixed vector in a jump table.
// R7 - Pending requests are arbitrated; winner offered with level and action.
// R8 - Winner served as interrupt, event transfer or jump-table entry.
// R9 - Accepted only if level exceeds CPU level and global enable set.
// R10 - Requests at or below CPU level are not taken and stay pending.
// R11 - Interrupt pushes status, segment in segmented mode, and return address.
// R12 - Event transfer moves one word or byte between two addresses.
// R13 - Event transfer halts the program and pushes nothing.
// R14 - Event transfers use the same level and group arbitration.
// R15 - Hardware traps outrank all requests and are served at once; the code holds them until a running entry sequence or transfer ends.
// R16 - Non-maskable pin raises a trap regardless of priorities.
// R17 - Trap instruction raises a software trap at its named vector.
// R18 - Every trap saves program status on the stack first.
// R19 - Acceptance clears the node's pending flag automatically.
// R20 - Enabled pending flag starts arbitration next cycle unless one runs.
// R21 - Level is a 4-bit field; group 2 bits plus extension bit.
// R22 - Equal levels are resolved by the highest group sub-level.
`timescale 1ns/1ps
module vipc_top
   import vipc_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone classic slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [11:0]                   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic [31:0]                        wb_dat_o,
   output logic                               wb_ack_o,
   // Request sources
   input  wire logic [vipc_pkg::NODES-1:0]    node_evt_i,
   input  wire logic [vipc_pkg::EXT_N-1:0]    ext_evt_i,
   input  wire logic [vipc_pkg::HWT_N-1:0]    hw_trap_i,
   input  wire logic                          nmi_i,
   input  wire logic                          sw_trap_i,
   input  wire logic [vipc_pkg::SLOT_W-1:0]   sw_vec_i,
   // Action offer to the core
   output logic                               act_req_o,
   output logic [vipc_pkg::NODE_W-1:0]        act_node_o,
   output logic [vipc_pkg::LVL_W-1:0]         act_lvl_o,
   output vipc_pkg::vipc_act_t                act_kind_o,
   // Stack push and branch
   output logic                               stk_req_o,
   output vipc_pkg::vipc_push_t               stk_sel_o,
   input  wire logic                          stk_ack_i,
   output logic                               br_o,
   output logic [31:0]                        br_addr_o,
   // Event transfer memory port
   output logic                               halt_o,
   output logic                               mem_req_o,
   output logic                               mem_we_o,
   output logic                               mem_byte_o,
   output logic [31:0]                        mem_addr_o,
   output logic [15:0]                        mem_wdata_o,
   input  wire logic [15:0]                   mem_rdata_i,
   input  wire logic                          mem_ack_i
);
   // ==========================================================
   // State
   typedef enum {ST_IDLE, ST_ARB, ST_OFFER, ST_ENTRY, ST_XRD, ST_XWR} vipc_st_t;

   vipc_st_t             st_q;
   logic [NODES-1:0]     flag_q;
   logic [NODES-1:0]     en_q;
   logic [LVL_W-1:0]     lvl_q   [NODES];
   logic [GRP_W-1:0]     grp_q   [NODES];
   logic [1:0]           kind_q  [NODES];
   logic [CH_W-1:0]      chan_q  [NODES];
   logic [NODE_W-1:0]    route_q [EXT_N];
   logic [31:0]          src_q   [CH_N];
   logic [31:0]          dst_q   [CH_N];
   logic [CH_N-1:0]      cbyte_q;
   logic [LVL_W-1:0]     plvl_q;
   logic                 gie_q;
   logic                 seg_q;
   logic [31:0]          vbase_q;
   logic [HWT_N-1:0]     hwt_q;
   logic                 nmi_q;
   logic                 nmi_d1_q;
   logic                 swt_q;
   logic [SLOT_W-1:0]    swv_q;
   logic [NODE_W-1:0]    win_q;
   logic [LVL_W-1:0]     wlvl_q;
   logic                 ack_q;
   logic [31:0]          rdat_q;
   logic [15:0]          xdat_q;
   logic                 mreq_q;
   logic                 accept;
   logic                 trap_go;
   logic                 es_busy;

   // ==========================================================
   // Helpers
   function automatic logic in_win(input logic [11:0] a, input logic [11:0] b,
                                   input logic [11:0] len);
      return (a >= b) && (a < b + len);
   endfunction

   function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                             input logic [SLOT_W-1:0] s);
      return base + {22'h000000, s, 2'b00}; // R6
   endfunction

   // ==========================================================
   // Wishbone decode
   logic              wb_req;
   logic              wb_wr;
   logic [9:0]        widx;
   logic              hit_ctrl;
   logic              hit_mode;
   logic              hit_route;
   logic              hit_ch;
   logic [NODE_W-1:0] nidx;
   logic [CH_W-1:0]   cidx;
   logic [11:0]       cofs;

   assign wb_req    = wb_cyc_i & wb_stb_i;
   assign wb_wr     = wb_req & wb_we_i & ack_q;
   assign widx      = wb_adr_i[11:2];
   assign nidx      = widx[NODE_W-1:0];
   assign hit_ctrl  = in_win(wb_adr_i, CTRL_BASE, 12'(NODES * 4));
   assign hit_mode  = in_win(wb_adr_i, MODE_BASE, 12'(NODES * 4));
   assign hit_route = in_win(wb_adr_i, ROUTE_BASE, 12'(EXT_N * 4));
   assign hit_ch    = in_win(wb_adr_i, CH_BASE, 12'(CH_N * 16));
   assign cidx      = wb_adr_i[CH_W+3:4];
   assign cofs      = {8'h00, wb_adr_i[3:0]};
   assign wb_ack_o  = ack_q;
   assign wb_dat_o  = rdat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req & ~ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_req & ~ack_q) begin
         rdat_q <= 32'h0000_0000;
         if (hit_ctrl) begin
            rdat_q[F_GRP +: 2]    <= grp_q[nidx][1:0]; // R3 R21
            rdat_q[F_LVL +: 4]    <= lvl_q[nidx];
            rdat_q[F_EN]          <= en_q[nidx];
            rdat_q[F_FLAG]        <= flag_q[nidx];
            rdat_q[F_GEXT]        <= (GRP_W > 2) ? grp_q[nidx][GRP_W-1] : 1'b0;
         end else if (hit_mode) begin
            rdat_q[F_KIND +: 2]   <= kind_q[nidx];
            rdat_q[F_CH +: CH_W]  <= chan_q[nidx];
         end else if (wb_adr_i == CPU_OFS) begin
            rdat_q[F_PLVL +: 4]   <= plvl_q;
            rdat_q[F_GIE]         <= gie_q;
            rdat_q[F_SEG]         <= seg_q;
         end else if (wb_adr_i == VBASE_OFS) begin
            rdat_q <= vbase_q;
         end else if (wb_adr_i == STAT_OFS) begin
            rdat_q[NODE_W-1:0]    <= win_q;
            rdat_q[11:8]          <= wlvl_q;
            rdat_q[16]            <= (st_q != ST_IDLE);
            rdat_q[24 +: HWT_N]   <= hwt_q;
         end else if (hit_route) begin
            rdat_q[NODE_W-1:0]    <= route_q[widx[2:0]];
         end else if (hit_ch) begin
            if (cofs == CH_SRC) rdat_q <= src_q[cidx];
            if (cofs == CH_DST) rdat_q <= dst_q[cidx];
            if (cofs == CH_CTL) rdat_q[0] <= cbyte_q[cidx];
         end
      end
   end

   // ==========================================================
   // Configuration writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q    <= '0;
         cbyte_q <= '0;
         plvl_q  <= 4'h0;
         gie_q   <= 1'b0;
         seg_q   <= 1'b0;
         vbase_q <= VBASE_RST;
         for (int i = 0; i < NODES; i++) begin
            lvl_q[i]  <= 4'h0;
            grp_q[i]  <= '0;
            kind_q[i] <= 2'h0;
            chan_q[i] <= '0;
         end
         for (int i = 0; i < EXT_N; i++) route_q[i] <= '0;
         for (int i = 0; i < CH_N; i++) begin
            src_q[i] <= 32'h0000_0000;
            dst_q[i] <= 32'h0000_0000;
         end
      end else begin
         // Entering an interrupt lifts the task to the winner's level
         if (st_q == ST_OFFER && accept && kind_q[win_q] == VIPC_ACT_INT) begin
            plvl_q <= wlvl_q;
         end
         if (wb_wr) begin
            if (hit_ctrl && wb_sel_i[0]) begin
               grp_q[nidx][1:0] <= wb_dat_i[F_GRP +: 2]; // R21
               lvl_q[nidx]      <= wb_dat_i[F_LVL +: 4];
               en_q[nidx]       <= wb_dat_i[F_EN];
            end
            if (hit_ctrl && wb_sel_i[1] && GRP_W > 2) begin
               grp_q[nidx][GRP_W-1] <= wb_dat_i[F_GEXT]; // R2
            end
            if (hit_mode && wb_sel_i[0]) begin
               kind_q[nidx] <= wb_dat_i[F_KIND +: 2];
               chan_q[nidx] <= wb_dat_i[F_CH +: CH_W];
            end
            if (wb_adr_i == CPU_OFS && wb_sel_i[0]) begin
               plvl_q <= wb_dat_i[F_PLVL +: 4];
               gie_q  <= wb_dat_i[F_GIE];
               seg_q  <= wb_dat_i[F_SEG];
            end
            if (wb_adr_i == VBASE_OFS) vbase_q <= wb_dat_i;
            if (hit_route && wb_sel_i[0]) route_q[widx[2:0]] <= wb_dat_i[NODE_W-1:0];
            if (hit_ch && cofs == CH_SRC) src_q[cidx] <= wb_dat_i;
            if (hit_ch && cofs == CH_DST) dst_q[cidx] <= wb_dat_i;
            if (hit_ch && cofs == CH_CTL) cbyte_q[cidx] <= wb_dat_i[0];
         end
      end
   end

   // ==========================================================
   // Request flags: source event beats software write beats accept clear
   logic [NODES-1:0] evt_set;
   logic [NODES-1:0] acc_clr;

   always_comb begin
      evt_set = node_evt_i; // R4
      for (int e = 0; e < EXT_N; e++) begin
         if (ext_evt_i[e]) evt_set[route_q[e]] = 1'b1; // R5
      end
   end

   generate
      for (genvar i = 0; i < NODES; i++) begin : g_flag
         assign acc_clr[i] = (st_q == ST_OFFER) && accept && (win_q == NODE_W'(i));
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               flag_q[i] <= 1'b0;
            end else if (evt_set[i]) begin
               flag_q[i] <= 1'b1; // R1 R3
            end else if (wb_wr && hit_ctrl && wb_sel_i[0] && nidx == NODE_W'(i)) begin
               flag_q[i] <= wb_dat_i[F_FLAG];
            end else if (acc_clr[i]) begin
               flag_q[i] <= 1'b0; // R19
            end
         end
      end
   endgenerate

   // ==========================================================
   // Level and group arbitration, common to interrupts and transfers
   logic                    any_req;
   logic [NODE_W-1:0]       best_n;
   logic [LVL_W+GRP_W-1:0]  best_k;

   always_comb begin
      any_req = 1'b0;
      best_n  = '0;
      best_k  = '0;
      for (int i = 0; i < NODES; i++) begin
         // Strict compare: a duplicated level/group pair resolves to the lower node
         if (flag_q[i] && en_q[i] && (!any_req || {lvl_q[i], grp_q[i]} > best_k)) begin
            any_req = 1'b1; // R7 R14
            best_n  = NODE_W'(i);
            best_k  = {lvl_q[i], grp_q[i]}; // R22
         end
      end
   end

   // R9 R10
   assign accept = flag_q[win_q] && en_q[win_q] && gie_q && (wlvl_q > plvl_q) && !trap_go;

   // ==========================================================
   // Traps: captured until served, ahead of every request
   logic              trap_any;
   logic [SLOT_W-1:0] trap_slot;
   logic [HWT_N-1:0]  hwt_clr;

   always_comb begin
      trap_any  = 1'b1;
      hwt_clr   = '0;
      trap_slot = SLOT_NMI; // R16
      if (!nmi_q) begin
         trap_any = 1'b0;
         for (int t = HWT_N - 1; t >= 0; t--) begin
            if (hwt_q[t]) begin
               trap_any  = 1'b1;
               trap_slot = SLOT_HWT0 + SLOT_W'(t);
            end
         end
         if (!trap_any && swt_q) begin
            trap_any  = 1'b1;
            trap_slot = swv_q; // R17
         end
      end
      if (!nmi_q && hwt_q != '0) hwt_clr = hwt_q & ~(hwt_q - 1'b1);
   end

   assign trap_go = trap_any && !es_busy && (st_q != ST_ENTRY) &&
                    (st_q != ST_XRD) && (st_q != ST_XWR);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hwt_q    <= '0;
         nmi_q    <= 1'b0;
         nmi_d1_q <= 1'b0;
         swt_q    <= 1'b0;
         swv_q    <= '0;
      end else begin
         nmi_d1_q <= nmi_i;
         // A fresh event in the take cycle survives the clear
         hwt_q <= hw_trap_i | (hwt_q & ~(trap_go ? hwt_clr : '0)); // R15
         if (nmi_i && !nmi_d1_q) begin
            nmi_q <= 1'b1; // R16
         end else if (trap_go && nmi_q) begin
            nmi_q <= 1'b0;
         end
         if (sw_trap_i) begin
            swt_q <= 1'b1;
            swv_q <= sw_vec_i;
         end else if (trap_go && !nmi_q && hwt_q == '0) begin
            swt_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Control sequence
   logic        es_start;
   logic        es_push;
   logic [31:0] es_vec;

   always_comb begin
      es_start = 1'b0;
      es_push  = 1'b1;
      es_vec   = slot_addr(vbase_q, trap_slot);
      if (trap_go) begin
         es_start = 1'b1; // R15 R18
      end else if (st_q == ST_OFFER && accept && kind_q[win_q] != VIPC_ACT_XFER) begin
         es_start = 1'b1; // R8
         es_push  = (kind_q[win_q] == VIPC_ACT_INT);
         es_vec   = slot_addr(vbase_q, SLOT_INT0 + SLOT_W'(win_q));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q   <= ST_IDLE;
         win_q  <= '0;
         wlvl_q <= 4'h0;
         xdat_q <= 16'h0000;
         mreq_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (trap_go) st_q <= ST_ENTRY;
               else if (any_req) st_q <= ST_ARB; // R20
            end
            ST_ARB: begin
               if (trap_go) begin
                  st_q <= ST_ENTRY;
               end else begin
                  win_q  <= best_n;
                  wlvl_q <= best_k[LVL_W+GRP_W-1:GRP_W];
                  st_q   <= ST_OFFER;
               end
            end
            ST_OFFER: begin
               if (trap_go || (accept && kind_q[win_q] != VIPC_ACT_XFER)) begin
                  st_q <= ST_ENTRY;
               end else if (accept) begin
                  mreq_q <= 1'b1; // R12
                  st_q   <= ST_XRD;
               end else begin
                  st_q <= ST_IDLE; // R10
               end
            end
            ST_ENTRY: if (!es_busy) st_q <= ST_IDLE;
            ST_XRD: if (mem_ack_i) begin
               xdat_q <= mem_rdata_i;
               st_q   <= ST_XWR;
            end
            ST_XWR: if (mem_ack_i) begin
               mreq_q <= 1'b0;
               st_q   <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   logic [CH_W-1:0] xch;
   assign xch         = chan_q[win_q];
   assign act_req_o   = (st_q == ST_OFFER);
   assign act_node_o  = win_q;
   assign act_lvl_o   = wlvl_q;
   assign act_kind_o  = vipc_act_t'(kind_q[win_q]);
   // Core is frozen and nothing is stacked while a transfer runs
   assign halt_o      = (st_q == ST_XRD) || (st_q == ST_XWR); // R13
   assign mem_req_o   = mreq_q;
   assign mem_we_o    = (st_q == ST_XWR);
   assign mem_byte_o  = cbyte_q[xch];
   assign mem_addr_o  = (st_q == ST_XWR) ? dst_q[xch] : src_q[xch];
   assign mem_wdata_o = xdat_q;

   vipc_entry_seq u_entry (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .start_i   (es_start),
      .push_i    (es_push),
      .seg_i     (seg_q),
      .vec_i     (es_vec),
      .stk_ack_i (stk_ack_i),
      .stk_req_o (stk_req_o),
      .stk_sel_o (stk_sel_o),
      .br_o      (br_o),
      .br_addr_o (br_addr_o),
      .busy_o    (es_busy)
   );
endmodule

/* bench/vipc_chk_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checks
module vipc_chk
   import vipc_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire logic                 act_req_o,
   input wire logic                 stk_req_o,
   input wire vipc_pkg::vipc_push_t stk_sel_o,
   input wire logic                 stk_ack_i,
   input wire logic                 br_o,
   input wire logic                 halt_o,
   input wire logic                 mem_req_o,
   input wire logic                 mem_we_o,
   input wire logic                 mem_ack_i,
   input wire logic                 nmi_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_timing: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("bus answer late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer too long");
   chk_offer_once: assert property (act_req_o |=> !act_req_o)
      else $error("offer held two cycles");
   chk_push_first: assert property ($rose(stk_req_o) |-> stk_sel_o == VIPC_PUSH_STAT)
      else $error("status not pushed first");
   chk_push_hold: assert property ((stk_req_o && !stk_ack_i) |=> stk_req_o && $stable(stk_sel_o))
      else $error("push dropped before answer");
   chk_xfer_quiet: assert property (halt_o |-> !stk_req_o && !br_o)
      else $error("push or branch during transfer");
   chk_read_write: assert property ((mem_req_o && !mem_we_o && mem_ack_i) |-> ##[1:3] (mem_req_o && mem_we_o))
      else $error("write does not follow read");
   chk_br_pulse: assert property (br_o |=> !br_o)
      else $error("branch pulse too long");
   chk_nmi_trap: assert property ($rose(nmi_i) |-> ##[1:30] br_o)
      else $error("nmi not taken");
   cover property (br_o);
   cover property (mem_req_o && mem_we_o);
   cover property (act_req_o);
endmodule

bind vipc_top vipc_chk vipc_chk_i (.*);

/* bench/vipc_core_model.sv */
`timescale 1ns/1ps
// ==========
// Core side: alternates prompt and slow answers
module vipc_core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stk_req_i,
   input  wire logic        mem_req_i,
   output logic             stk_ack_o,
   output logic             mem_ack_o,
   output logic [15:0]      mem_rdata_o
);
   logic       req;
   logic       ack_q;
   logic       slow_q;
   logic [2:0] cnt_q;
   assign req = stk_req_i | mem_req_i;
   always_ff @(posedge clk_i) begin
      if (rst_i || !req || ack_q) cnt_q <= 3'h0;
      else cnt_q <= cnt_q + 3'h1;
   end
   always_ff @(posedge clk_i) begin
      ack_q <= !rst_i && req && !ack_q && (cnt_q == (slow_q ? 3'h3 : 3'h0));
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) slow_q <= 1'b0;
      else if (ack_q) slow_q <= !slow_q;
   end
   assign stk_ack_o = ack_q & stk_req_i;
   assign mem_ack_o = ack_q & mem_req_i;
   // Inverse value off the answer cycle so a late sample cannot pass
   assign mem_rdata_o = mem_ack_o ? 16'hA5C3 : 16'h5A3C;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   import vipc_pkg::*;
   logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic              nmi_i, sw_trap_i, act_req_o, stk_req_o, stk_ack_i, br_o;
   logic              halt_o, mem_req_o, mem_we_o, mem_byte_o, mem_ack_i;
   logic [11:0]       wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [31:0]       wb_dat_i, wb_dat_o, br_addr_o, mem_addr_o, rd;
   logic [NODES-1:0]  node_evt_i;
   logic [EXT_N-1:0]  ext_evt_i;
   logic [HWT_N-1:0]  hw_trap_i;
   logic [SLOT_W-1:0] sw_vec_i;
   logic [NODE_W-1:0] act_node_o;
   logic [LVL_W-1:0]  act_lvl_o;
   logic [15:0]       mem_wdata_o, mem_rdata_i;
   vipc_act_t         act_kind_o;
   vipc_push_t        stk_sel_o;
   int                err_count, tests_run, cyc_n;
   vipc_top vipc_top_i (.*);
   vipc_core_model vipc_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .stk_req_i(stk_req_o),
      .mem_req_i(mem_req_o), .stk_ack_o(stk_ack_i), .mem_ack_o(mem_ack_i),
      .mem_rdata_o(mem_rdata_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ==========
   // Tasks
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   function automatic logic [11:0] ca(input int n);
      return CTRL_BASE + 12'(4 * n);
   endfunction
   task evt(input logic [NODES-1:0] m);
      @(posedge clk_i);
      node_evt_i <= m;
      @(posedge clk_i);
      node_evt_i <= '0;
   endtask
   task br_chk(input logic [SLOT_W-1:0] s);
      do @(posedge clk_i); while (br_o !== 1'b1);
      `CHK(br_addr_o, 32'h1000 + {22'h0, s, 2'b00})
   endtask
   task mem_wait(input logic we);
      do @(posedge clk_i); while ((mem_req_o & mem_ack_i & (mem_we_o == we)) !== 1'b1);
   endtask
   // ==========
   // Sequence
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, nmi_i, sw_trap_i} = 6'h20;
      {wb_adr_i, wb_dat_i, node_evt_i, ext_evt_i, hw_trap_i} = '0;
      wb_sel_i = 4'hF;
      sw_vec_i = 8'h40;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ca(127), 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b0, 12'hFFC, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b1, VBASE_OFS, 32'h1000);
      wb(1'b1, CPU_OFS, 32'h10);
      wb(1'b1, ca(127), 32'h14D);
      wb(1'b0, ca(127), 32'h0);
      `CHK(rd, 32'h14D)
      evt(128'h1 << 127);
      do @(posedge clk_i); while (act_req_o !== 1'b1);
      `CHK(act_node_o, 7'h7F)
      `CHK(act_lvl_o, 4'h3)
      `CHK(act_kind_o, VIPC_ACT_INT)
      br_chk(SLOT_INT0 + 8'd127);
      wb(1'b0, ca(127), 32'h0);
      `CHK(rd, 32'h14D)
      wb(1'b1, ca(6), 32'h4C);
      wb(1'b1, ca(7), 32'h4F);
      evt(128'hC0);
      repeat (20) @(posedge clk_i);
      wb(1'b0, ca(6), 32'h0);
      `CHK(rd, 32'hCC)
      wb(1'b1, CPU_OFS, 32'h0);
      repeat (20) @(posedge clk_i);
      wb(1'b0, ca(7), 32'h0);
      `CHK(rd, 32'hCF)
      wb(1'b1, CPU_OFS, 32'h10);
      br_chk(SLOT_INT0 + 8'd7);
      wb(1'b1, CPU_OFS, 32'h30);
      br_chk(SLOT_INT0 + 8'd6);
      wb(1'b1, ROUTE_BASE, 32'hA);
      wb(1'b1, ca(10), 32'h58);
      @(posedge clk_i);
      ext_evt_i <= 8'h1;
      @(posedge clk_i);
      ext_evt_i <= 8'h0;
      br_chk(SLOT_INT0 + 8'd10);
      nmi_i <= 1'b1;
      br_chk(SLOT_NMI);
      nmi_i <= 1'b0;
      hw_trap_i <= 8'h81;
      @(posedge clk_i);
      hw_trap_i <= 8'h0;
      br_chk(SLOT_HWT0);
      br_chk(SLOT_HWT0 + 8'd7);
      sw_trap_i <= 1'b1;
      @(posedge clk_i);
      sw_trap_i <= 1'b0;
      br_chk(8'h40);
      wb(1'b1, MODE_BASE + 12'h24, 32'h1);
      wb(1'b1, CH_BASE + CH_SRC, 32'h2000);
      wb(1'b1, CH_BASE + CH_DST, 32'h3000);
      wb(1'b1, ca(9), 32'h7C);
      evt(128'h200);
      mem_wait(1'b0);
      `CHK(mem_addr_o, 32'h2000)
      mem_wait(1'b1);
      `CHK(mem_addr_o, 32'h3000)
      `CHK(mem_wdata_o, 16'hA5C3)
      `CHK(halt_o, 1'b1)
      `CHK(mem_byte_o, 1'b0)
      wb(1'b0, ca(9), 32'h0);
      `CHK(rd, 32'h7C)
      wb(1'b1, MODE_BASE + 12'h24, 32'h2);
      evt(128'h200);
      br_chk(SLOT_INT0 + 8'd9);
      end_of_test();
   end
endmodule
